// ### rtl/tmr2_pkg.sv
// Timer two package: register offsets, field positions and timing counts
package tmr2_pkg;
  // Special-function register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_MODE = 8'hc9;
  localparam logic [7:0] ADDR_RCAP_LOW = 8'hca;
  localparam logic [7:0] ADDR_RCAP_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  // Control register fields
  localparam int CTL_OVF = 7;
  localparam int CTL_EXF = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TX_CLOCK_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CNT = 1;
  localparam int CTL_CAP = 0;
  // Mode register fields
  localparam int MOD_CLKOE = 1;
  localparam int MOD_DOWN_COUNT_ENABLE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Oscillator clocks per machine cycle
  localparam logic [3:0] TWELVE_CLOCK_CYCLE = 4'hc;
  localparam logic [3:0] SIX_CLOCK_CYCLE = 4'h6;
  // Baud and clock-out use count every second oscillator clock
  localparam logic [3:0] BAUD_DIVIDE = 4'h2;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  typedef enum logic [1:0] {
    TMR2_OFF = 2'b00,
    TMR2_RELOAD = 2'b01,
    TMR2_CAPTURE = 2'b10,
    TMR2_BAUD = 2'b11
  } tmr2_mode_t;
endpackage

// ### rtl/tmr2_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tmr2_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin_i};
    level_next = level_reg;
    // First stage feeds only the second; stages two and three must agree
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      stage_reg <= 3'h7;
      level_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule
`default_nettype wire

// ### rtl/tmr2_top.sv
// Sixteen-bit timer two with capture, reload, baud clocks and clock output
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Timer function counts once per machine cycle of twelve or six clocks, except in baud and clock-out use (every second clock).
// - Counter function samples count pin per machine cycle, counts high-then-low.
// - Serial clock select means baud; else capture bit picks capture or reload.
// - Capture mode without trigger enable is plain timer setting overflow flag.
// - Capture with trigger enable: trigger falling edge copies count, sets flag.
// - Up auto-reload overflows past FFFF, sets flag, reloads from reload regs.
// - Up reload with trigger enable also reloads on trigger falling edge.
// - Down-enabled with trigger pin high counts up, reloads on overflow.
// - Down-enabled with pin low counts down, loads FFFF at reload value.
// - Down-enabled toggles external flag on wrap; it raises no interrupt.
// - Reset clears down-count enable, so reload counts up.
// - Clock-out needs timer function and clock-out enable; run bit gates it.
// - Clock-out frequency is oscillator over four times (65536 minus reload).
// - Baud and reload-mode clock-out rollovers raise no interrupt; they share reload.
// - Overflow flag set on overflow except in baud use and reload-mode clock-out; software clears it.
// - External flag requests interrupt when enabled, except with down-count enabled; software must clear it.
// - Receive clock select routes overflow pulses to serial receive clock.
// - Transmit clock select routes overflow pulses to serial transmit clock.
// - Trigger edges ignored without trigger enable or while clocking serial.
// - Baud use ignores capture bit and always reloads on overflow.
// - Control and mode register bit layout as listed.
// - Run bit starts counting; counter select picks timer or pin edges.
module tmr2_top #(
  parameter logic SIX_CLOCK_MODE = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // Pins
  input wire logic count_input_pin_i,
  input wire logic ext_trigger_pin_i,
  output logic clockout_pin_o,
  output logic clockout_pin_oe_o,
  // Interrupt enable from the core and request
  input wire logic irq_enable_i,
  output logic irq_o,
  // Serial port overflow clocks
  input wire logic other_timer_ovf_i,
  output logic rx_clock_o,
  output logic tx_clock_o
);
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [15:0] rcap_reg;
  logic [15:0] rcap_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [3:0] prescale_reg;
  logic [3:0] prescale_next;
  logic cnt_sample_reg;
  logic cnt_sample_next;
  logic trig_prev_reg;
  logic trig_prev_next;
  logic clockout_reg;
  logic clockout_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic rx_clk_reg;
  logic rx_clk_next;
  logic tx_clk_reg;
  logic tx_clk_next;

  logic cnt_level;
  logic trig_level;
  logic [1:0] pin_bus;
  logic [1:0] level_bus;

  // Both pins share one filter design; bit 0 counts, bit 1 triggers
  assign pin_bus = {ext_trigger_pin_i, count_input_pin_i};
  for (genvar i = 0; i < 2; i++) begin : g_pin_sync
    tmr2_sync u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(pin_bus[i]),
      .level_o(level_bus[i])
    );
  end
  assign cnt_level = level_bus[0];
  assign trig_level = level_bus[1];

  // Mode decode, used for next state and for readback reasoning
  function automatic tmr2_pkg::tmr2_mode_t mode_of(input logic [7:0] ctl);
    if (!ctl[tmr2_pkg::CTL_RUN]) begin
      mode_of = tmr2_pkg::TMR2_OFF;
    end else if (ctl[tmr2_pkg::CTL_RCLK] || ctl[tmr2_pkg::CTL_TX_CLOCK_SELECT]) begin
      mode_of = tmr2_pkg::TMR2_BAUD;
    end else if (ctl[tmr2_pkg::CTL_CAP]) begin
      mode_of = tmr2_pkg::TMR2_CAPTURE;
    end else begin
      mode_of = tmr2_pkg::TMR2_RELOAD;
    end
  endfunction

  // One strobe aimed at one register address
  function automatic logic addr_hit(input logic strobe,
      input logic [7:0] addr, input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  tmr2_pkg::tmr2_mode_t mode;
  logic baud_use;
  logic fast_clock;
  logic [3:0] period;
  logic tick;
  logic step;
  logic down;
  logic wrap_up;
  logic wrap_down;
  logic wrap;
  logic trig_fall;
  logic trig_event;
  logic wr_ctl;

  always_comb begin
    mode = mode_of(control_reg);
    baud_use = control_reg[tmr2_pkg::CTL_RCLK]
      || control_reg[tmr2_pkg::CTL_TX_CLOCK_SELECT];
    // Clock-out needs timer function, so it shares the fast count rate
    fast_clock = baud_use || (mode_reg[tmr2_pkg::MOD_CLKOE]
      && !control_reg[tmr2_pkg::CTL_CNT]);
    if (fast_clock) begin
      period = tmr2_pkg::BAUD_DIVIDE;
    end else if (SIX_CLOCK_MODE) begin
      period = tmr2_pkg::SIX_CLOCK_CYCLE;
    end else begin
      period = tmr2_pkg::TWELVE_CLOCK_CYCLE;
    end
    prescale_next = prescale_reg + 4'h1;
    tick = 1'b0;
    // Compare, not equality, so a drop from twelve to two ends at once
    if (prescale_reg >= period - 4'h1) begin
      prescale_next = 4'h0;
      tick = 1'b1;
    end
    // Pin sampled once per machine cycle; high then low makes one count
    cnt_sample_next = cnt_sample_reg;
    if (tick) begin
      cnt_sample_next = cnt_level;
    end
    if (mode == tmr2_pkg::TMR2_OFF) begin
      step = 1'b0;
    end else if (control_reg[tmr2_pkg::CTL_CNT] && !baud_use) begin
      step = tick && cnt_sample_reg && !cnt_level;
    end else begin
      step = tick;
    end
    down = (mode == tmr2_pkg::TMR2_RELOAD)
      && mode_reg[tmr2_pkg::MOD_DOWN_COUNT_ENABLE] && !trig_level;
    wrap_up = step && !down && (count_reg == tmr2_pkg::COUNT_TOP);
    wrap_down = step && down && (count_reg == rcap_reg);
    wrap = wrap_up || wrap_down;
    trig_prev_next = trig_level;
    trig_fall = trig_prev_reg && !trig_level;
    // Direction use of the pin is not a trigger; serial use blocks it
    trig_event = trig_fall && control_reg[tmr2_pkg::CTL_EXEN]
      && !baud_use && (mode != tmr2_pkg::TMR2_OFF)
      && !((mode == tmr2_pkg::TMR2_RELOAD)
        && mode_reg[tmr2_pkg::MOD_DOWN_COUNT_ENABLE]);
  end

  // Register writes and counting; hardware sets win over software writes
  always_comb begin
    wr_ctl = addr_hit(sfr_wr_i, sfr_addr_i, tmr2_pkg::ADDR_CONTROL);
    control_next = control_reg;
    mode_next = mode_reg;
    rcap_next = rcap_reg;
    count_next = count_reg;
    if (wr_ctl) begin
      control_next = sfr_wdata_i;
    end
    if (addr_hit(sfr_wr_i, sfr_addr_i, tmr2_pkg::ADDR_MODE)) begin
      mode_next = sfr_wdata_i[1:0];
    end
    if (addr_hit(sfr_wr_i, sfr_addr_i, tmr2_pkg::ADDR_RCAP_LOW)) begin
      rcap_next[7:0] = sfr_wdata_i;
    end
    if (addr_hit(sfr_wr_i, sfr_addr_i, tmr2_pkg::ADDR_RCAP_HIGH)) begin
      rcap_next[15:8] = sfr_wdata_i;
    end
    if (addr_hit(sfr_wr_i, sfr_addr_i, tmr2_pkg::ADDR_COUNT_LOW)) begin
      count_next[7:0] = sfr_wdata_i;
    end
    if (addr_hit(sfr_wr_i, sfr_addr_i, tmr2_pkg::ADDR_COUNT_HIGH)) begin
      count_next[15:8] = sfr_wdata_i;
    end
    if (step) begin
      if (down) begin
        count_next = count_reg - 16'h1;
      end else begin
        count_next = count_reg + 16'h1;
      end
    end
    case (mode)
      tmr2_pkg::TMR2_CAPTURE: begin
        if (wrap) begin
          control_next[tmr2_pkg::CTL_OVF] = 1'b1;
        end
        if (trig_event) begin
          rcap_next = count_reg;
          control_next[tmr2_pkg::CTL_EXF] = 1'b1;
        end
      end
      tmr2_pkg::TMR2_RELOAD: begin
        if (wrap_up) begin
          count_next = rcap_reg;
        end
        if (wrap_down) begin
          count_next = tmr2_pkg::COUNT_TOP;
        end
        // Clock-out use rolls over silently, just as baud use does
        if (wrap && !fast_clock) begin
          control_next[tmr2_pkg::CTL_OVF] = 1'b1;
        end
        if (wrap && mode_reg[tmr2_pkg::MOD_DOWN_COUNT_ENABLE]) begin
          control_next[tmr2_pkg::CTL_EXF] =
            ~control_reg[tmr2_pkg::CTL_EXF];
        end
        if (trig_event) begin
          count_next = rcap_reg;
          control_next[tmr2_pkg::CTL_EXF] = 1'b1;
        end
      end
      tmr2_pkg::TMR2_BAUD: begin
        // No overflow flag here, and the capture bit is ignored
        if (wrap) begin
          count_next = rcap_reg;
        end
      end
      default: begin
      end
    endcase
  end

  // Pin, interrupt and serial clocks
  always_comb begin
    clockout_next = clockout_reg;
    if (!mode_reg[tmr2_pkg::MOD_CLKOE]) begin
      clockout_next = 1'b0;
    end else if (wrap && fast_clock) begin
      clockout_next = ~clockout_reg;
    end
    // Down-count setting keeps the external flag off the request line
    irq_next = irq_enable_i && (control_reg[tmr2_pkg::CTL_OVF]
      || (control_reg[tmr2_pkg::CTL_EXF]
        && !mode_reg[tmr2_pkg::MOD_DOWN_COUNT_ENABLE]));
    rx_clk_next = control_reg[tmr2_pkg::CTL_RCLK] ? wrap
      : other_timer_ovf_i;
    tx_clk_next = control_reg[tmr2_pkg::CTL_TX_CLOCK_SELECT] ? wrap
      : other_timer_ovf_i;
  end

  // Read data stands until the next read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        tmr2_pkg::ADDR_CONTROL: rdata_next = control_reg;
        tmr2_pkg::ADDR_MODE: rdata_next = {6'h00, mode_reg};
        tmr2_pkg::ADDR_RCAP_LOW: rdata_next = rcap_reg[7:0];
        tmr2_pkg::ADDR_RCAP_HIGH: rdata_next = rcap_reg[15:8];
        tmr2_pkg::ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
        tmr2_pkg::ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Prescaler and pin sampling
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prescale_reg <= 4'h0;
      cnt_sample_reg <= 1'b1;
      trig_prev_reg <= 1'b1;
    end else begin
      prescale_reg <= prescale_next;
      cnt_sample_reg <= cnt_sample_next;
      trig_prev_reg <= trig_prev_next;
    end
  end

  // Software-visible registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      control_reg <= tmr2_pkg::CONTROL_RESET;
      mode_reg <= tmr2_pkg::MODE_RESET;
      rcap_reg <= {tmr2_pkg::DATA_RESET, tmr2_pkg::DATA_RESET};
      count_reg <= {tmr2_pkg::DATA_RESET, tmr2_pkg::DATA_RESET};
    end else begin
      control_reg <= control_next;
      mode_reg <= mode_next;
      rcap_reg <= rcap_next;
      count_reg <= count_next;
    end
  end

  // Pin, request and serial clock outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      clockout_reg <= 1'b0;
      irq_reg <= 1'b0;
      rx_clk_reg <= 1'b0;
      tx_clk_reg <= 1'b0;
    end else begin
      clockout_reg <= clockout_next;
      irq_reg <= irq_next;
      rx_clk_reg <= rx_clk_next;
      tx_clk_reg <= tx_clk_next;
    end
  end

  // Read data
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;
  assign clockout_pin_o = clockout_reg;
  // Enable is the stored clock-out bit, so it too leaves a flip-flop
  assign clockout_pin_oe_o = mode_reg[tmr2_pkg::MOD_CLKOE];
  assign irq_o = irq_reg;
  assign rx_clock_o = rx_clk_reg;
  assign tx_clock_o = tx_clk_reg;
endmodule
`default_nettype wire

// ### dv/tmr2_checker.sv
// Port checker for timer two, bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module tmr2_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // Pins and serial clocks
  input wire logic clockout_pin_o,
  input wire logic irq_enable_i,
  input wire logic irq_o,
  input wire logic other_timer_ovf_i,
  input wire logic rx_clock_o,
  input wire logic tx_clock_o
);
  // Shadows of the bits that only software changes
  logic [5:0] ctl_reg;
  logic [5:0] ctl_next;
  logic [1:0] mod_reg;
  logic [1:0] mod_next;
  logic unmapped;
  always_comb begin
    ctl_next = ctl_reg;
    mod_next = mod_reg;
    if (sfr_wr_i && sfr_addr_i == tmr2_pkg::ADDR_CONTROL) begin
      ctl_next = sfr_wdata_i[5:0];
    end
    if (sfr_wr_i && sfr_addr_i == tmr2_pkg::ADDR_MODE) begin
      mod_next = sfr_wdata_i[1:0];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctl_reg <= 6'h00;
      mod_reg <= 2'h0;
    end else begin
      ctl_reg <= ctl_next;
      mod_reg <= mod_next;
    end
  end
  assign unmapped = sfr_addr_i < tmr2_pkg::ADDR_CONTROL
    || sfr_addr_i > tmr2_pkg::ADDR_COUNT_HIGH;
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_unmapped;
    sfr_rd_i && unmapped |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_hold;
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_mode;
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == tmr2_pkg::ADDR_MODE
      |=> sfr_rdata_o == {6'h00, mod_reg};
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  property p_ctl;
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == tmr2_pkg::ADDR_CONTROL
      |=> sfr_rdata_o[5:0] == ctl_reg;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_rx;
    !ctl_reg[5] |=> rx_clock_o == $past(other_timer_ovf_i);
  endproperty
  a_rx: assert property (p_rx) else $error("rx clock source");
  property p_tx_on;
    !ctl_reg[4] && other_timer_ovf_i |=> tx_clock_o;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx pulse lost");
  property p_tx_off;
    !ctl_reg[4] && !other_timer_ovf_i |=> !tx_clock_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx extra pulse");
  property p_irq;
    irq_o |-> $past(irq_enable_i);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not enabled");
  // Half period is at least two clocks even at reload ffff
  property p_clk;
    $changed(clockout_pin_o) |=> $stable(clockout_pin_o);
  endproperty
  a_clk: assert property (p_clk) else $error("clock out too fast");
  c_irq: cover property (irq_o);
  c_tx: cover property (tx_clock_o && ctl_reg[4]);
  c_clk: cover property ($rose(clockout_pin_o));
endmodule
bind tmr2_top tmr2_checker u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
  .clockout_pin_o(clockout_pin_o), .irq_enable_i(irq_enable_i),
  .irq_o(irq_o), .other_timer_ovf_i(other_timer_ovf_i),
  .rx_clock_o(rx_clock_o), .tx_clock_o(tx_clock_o));
`default_nettype wire

// ### dv/tmr2_serial_model.sv
// Serial port and other timer stand-in: overflow source and pulse counter
`timescale 1ns/1ps
`default_nettype none
module tmr2_serial_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Overflow clocks
  input wire logic rx_clock_i,
  input wire logic tx_clock_i,
  output var logic other_timer_ovf_o,
  output var int rx_count_o,
  output var int tx_count_o
);
  // Odd spacing so these pulses drift against the prescaler
  int div;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      div <= 0;
      other_timer_ovf_o <= 1'b0;
      rx_count_o <= 0;
      tx_count_o <= 0;
    end else begin
      div <= (div == 6) ? 0 : div + 1;
      other_timer_ovf_o <= (div == 6);
      rx_count_o <= rx_count_o + int'(rx_clock_i);
      tx_count_o <= tx_count_o + int'(tx_clock_i);
    end
  end
endmodule
`default_nettype wire

// ### dv/timer2_capture_reload_clockout_tb_top.sv
// Testbench for timer two: register sequences and pin stimulus
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_reload_clockout_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cnt_pin = 1'b1;
  logic trg_pin = 1'b1;
  logic irq_en = 1'b0;
  logic [7:0] rdata;
  logic ck_o, ck_oe, irq, ovf, rxc, txc, p;
  int rx_n, tx_n, bad_count, total_checks, n, d, e;
  initial forever #50 sys_clk_i = ~sys_clk_i;
  tmr2_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .count_input_pin_i(cnt_pin), .ext_trigger_pin_i(trg_pin),
    .clockout_pin_o(ck_o), .clockout_pin_oe_o(ck_oe),
    .irq_enable_i(irq_en), .irq_o(irq), .other_timer_ovf_i(ovf),
    .rx_clock_o(rxc), .tx_clock_o(txc));
  tmr2_serial_model model (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .rx_clock_i(rxc), .tx_clock_i(txc), .other_timer_ovf_o(ovf),
    .rx_count_o(rx_n), .tx_count_o(tx_n));
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk(rdata, x);
  endtask
  task automatic give_up(input int k);
    if (k >= 400) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wait_irq();
    for (n = 0; irq !== 1'b1 && n < 400; n++) cycles(1);
    give_up(n);
  endtask
  // Counts clocks up to the next rising edge of the clock-out pin
  task automatic wait_rise();
    n = 0;
    do begin
      p = ck_o;
      cycles(1);
      n++;
    end while (!(p === 1'b0 && ck_o === 1'b1) && n < 400);
    give_up(n);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 8'hc8; a <= 8'hcd; a++) rd_reg(8'(a), 8'h00);
    wr_reg(8'hc9, 8'hff);
    rd_reg(8'hc9, 8'h03);
    wr_reg(8'hc7, 8'h5a);
    rd_reg(8'hc7, 8'h00);
    wr_reg(8'hc9, 8'h00);
    wr_reg(8'hca, 8'hf0);
    wr_reg(8'hcb, 8'hff);
    wr_reg(8'hcc, 8'hfe);
    wr_reg(8'hcd, 8'hff);
    irq_en <= 1'b1;
    wr_reg(8'hc8, 8'h04);
    wait_irq();
    rd_reg(8'hcd, 8'hff);
    rd_reg(8'hcc, 8'hf0);
    rd_reg(8'hc8, 8'h84);
    wr_reg(8'hc8, 8'h00);
    cycles(2);
    chk({7'h00, irq}, 8'h00);
    // Down count with the direction pin low
    trg_pin <= 1'b0;
    wr_reg(8'hc9, 8'h01);
    wr_reg(8'hcc, 8'hf2);
    wr_reg(8'hc8, 8'h04);
    wait_irq();
    rd_reg(8'hcd, 8'hff);
    rd_reg(8'hcc, 8'hff);
    rd_reg(8'hc8, 8'hc4);
    wr_reg(8'hc8, 8'h44);
    cycles(3);
    chk({7'h00, irq}, 8'h00);
    // Capture in counter function with the count pin pulsed once
    wr_reg(8'hc8, 8'h00);
    wr_reg(8'hc9, 8'h00);
    trg_pin <= 1'b1;
    wr_reg(8'hcc, 8'h34);
    wr_reg(8'hcd, 8'h12);
    wr_reg(8'hc8, 8'h0f);
    cnt_pin <= 1'b0;
    cycles(30);
    cnt_pin <= 1'b1;
    cycles(30);
    trg_pin <= 1'b0;
    cycles(12);
    rd_reg(8'hca, 8'h35);
    rd_reg(8'hcb, 8'h12);
    rd_reg(8'hc8, 8'h4f);
    chk({7'h00, irq}, 8'h01);
    wr_reg(8'hc8, 8'h07);
    trg_pin <= 1'b1;
    cycles(12);
    trg_pin <= 1'b0;
    cycles(12);
    rd_reg(8'hc8, 8'h07);
    // Baud clocks and clock out together, reload fffe
    wr_reg(8'hc8, 8'h00);
    wr_reg(8'hca, 8'hfe);
    wr_reg(8'hcb, 8'hff);
    wr_reg(8'hcc, 8'hfe);
    wr_reg(8'hcd, 8'hff);
    wr_reg(8'hc9, 8'h02);
    cycles(1);
    chk({7'h00, ck_oe}, 8'h01);
    wr_reg(8'hc8, 8'h3c);
    wait_rise();
    wait_rise();
    chk(8'(n), 8'h08);
    d = tx_n;
    e = rx_n;
    trg_pin <= 1'b1;
    cycles(40);
    trg_pin <= 1'b0;
    cycles(40);
    chk(8'(tx_n - d), 8'h14);
    chk(8'(rx_n - e), 8'h14);
    rd_reg(8'hc8, 8'h3c);
    wr_reg(8'hc8, 8'h00);
    cycles(2);
    p = ck_o;
    cycles(20);
    chk({7'h00, ck_o}, {7'h00, p});
    // Clock out alone: fast count and no overflow flag
    wr_reg(8'hc8, 8'h04);
    wait_rise();
    wait_rise();
    chk(8'(n), 8'h08);
    rd_reg(8'hc8, 8'h04);
    chk({7'h00, irq}, 8'h00);
    // Up reload with trigger enable: a trigger edge reloads the count
    wr_reg(8'hc8, 8'h00);
    wr_reg(8'hc9, 8'h00);
    trg_pin <= 1'b1;
    wr_reg(8'hcc, 8'h00);
    wr_reg(8'hcd, 8'h10);
    wr_reg(8'hc8, 8'h0c);
    cycles(4);
    trg_pin <= 1'b0;
    cycles(8);
    rd_reg(8'hcd, 8'hff);
    rd_reg(8'hc8, 8'h4c);
    chk({7'h00, irq}, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
